// ---- rtl/aqss_params.svh ----
// Constants of the queue scan sequencer: offsets, field positions, resets.
// Assumes inclusion by the sequencer top module and its bench only.
`ifndef AQSS_PARAMS_SVH
`define AQSS_PARAMS_SVH

`define AQSS_ADR_CTRL      8'h00
`define AQSS_ADR_STAT      8'h04
`define AQSS_ADR_PTR       8'h08
`define AQSS_RGN_REG       2'h0
`define AQSS_RGN_CCW       2'h1
`define AQSS_RGN_RES       2'h2

`define AQSS_CTRL_MODE_LSB 0
`define AQSS_CTRL_SSE_BIT  2
`define AQSS_CTRL_IE_BIT   3
`define AQSS_CTRL_BQ2_LSB  8
`define AQSS_STAT_CF_BIT   0
`define AQSS_STAT_TOR_BIT  1
`define AQSS_STAT_PF_BIT   2
`define AQSS_STAT_QS_LSB   4
`define AQSS_PTR_CWP_LSB   0
`define AQSS_PTR_Q1D_LSB   8
`define AQSS_PTR_Q2D_LSB   16
`define AQSS_CCW_PAUSE_BIT 6

`define AQSS_EOQ_CHAN      6'h3F
`define AQSS_LAST_ENTRY    6'h3F
`define AQSS_FIRST_ENTRY   6'h00
`define AQSS_BQ2_RST       6'h3F
`define AQSS_QS_OFF        4'h0
`define AQSS_QS_PAUSED     4'h4
`define AQSS_QS_ACTIVE     4'h8

`endif

// ---- rtl/aqss_pkg.sv ----
// Types of the queue scan sequencer.
// Assumes the constants header sits beside it.
package aqss_pkg;

    typedef enum logic [1:0] {MODE_OFF, MODE_EDGE, MODE_GSINGLE, MODE_GCONT} aqss_mode_e;

    typedef enum logic [2:0] {ST_OFF, ST_ARM, ST_ISSUE, ST_CONV, ST_PAUSE} aqss_state_e;

    typedef struct packed {
        logic       pause;
        logic [5:0] chan;
    } aqss_ccw_s;

    typedef struct packed {
        logic       start;
        logic [5:0] chan;
    } aqss_conv_req_s;

    typedef struct packed {
        aqss_state_e    st;
        aqss_mode_e     mode;
        logic           single_scan_enable;
        logic           ie;
        logic [5:0]     bq2;
        logic [5:0]     command_word_pointer;
        logic [5:0]     q1d;
        logic           cf;
        logic           tor;
        logic           pf;
        logic           second;
        logic           eoq;
        logic           sync1;
        logic           sync2;
        logic           trig_d;
        logic           ack;
        logic [31:0]    dat;
        aqss_conv_req_s req;
        logic           irq;
    } aqss_state_s;

endpackage

// ---- rtl/aqss_top.sv ----
// Queue one scan sequencer with a classic Wishbone register slave.
// Assumes an analog converter on sys_clk that answers each start pulse
// with one conv_eoc pulse carrying conv_result; ext_trig is asynchronous.
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "aqss_params.svh"

module aqss_top
    import aqss_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [9:0]      wb_adr_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    input  wire logic            ext_trig,
    input  wire logic            conv_eoc,
    input  wire logic [9:0]      conv_result,
    output aqss_conv_req_s       conv_req,
    output logic                 q1_irq
);

    // ----------------------------------------------------------------
    // State and tables
    // ----------------------------------------------------------------
    aqss_state_s s_r;
    aqss_state_s s_nxt;
    aqss_ccw_s   ccw_mem [64];
    logic [9:0]  res_mem [64];

    logic        acc;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        rise;
    logic        gate;
    logic        gated;
    logic        end_here;
    logic        cf_set;
    logic        tor_set;
    logic        res_we;
    logic [3:0]  qs;
    logic [31:0] rd_val;
    aqss_ccw_s   cur;

    assign acc     = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign wr      = acc & wb_we_i;
    assign wr_ctrl = wr & (wb_adr_i[9:8] == `AQSS_RGN_REG)
                   & (wb_adr_i[7:0] == `AQSS_ADR_CTRL) & wb_sel_i[0];
    assign wr_stat = wr & (wb_adr_i[9:8] == `AQSS_RGN_REG)
                   & (wb_adr_i[7:0] == `AQSS_ADR_STAT) & wb_sel_i[0];
    assign rise    = s_r.sync2 & ~s_r.trig_d;
    assign gate    = s_r.sync2;
    assign gated   = (s_r.mode == MODE_GSINGLE) | (s_r.mode == MODE_GCONT);
    assign cur     = ccw_mem[s_r.command_word_pointer];
    // Any of the three ends of queue one
    assign end_here = s_r.eoq | (cur.chan == `AQSS_EOQ_CHAN) | (s_r.command_word_pointer == s_r.bq2);

    // Queue two never runs here, so only queue one shapes the field
    always_comb
    begin
        if (s_r.mode == MODE_OFF)
            qs = `AQSS_QS_OFF;
        else if (s_r.st == ST_PAUSE)
            qs = `AQSS_QS_PAUSED;
        else
            qs = `AQSS_QS_ACTIVE;
    end

    // ----------------------------------------------------------------
    // Register read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (wb_adr_i[9:8])
            `AQSS_RGN_REG:
            begin
                if (wb_adr_i[7:0] == `AQSS_ADR_CTRL)
                begin
                    rd_val[`AQSS_CTRL_MODE_LSB +: 2] = s_r.mode;
                    rd_val[`AQSS_CTRL_SSE_BIT]      = s_r.single_scan_enable;
                    rd_val[`AQSS_CTRL_IE_BIT]       = s_r.ie;
                    rd_val[`AQSS_CTRL_BQ2_LSB +: 6] = s_r.bq2;
                end
                else if (wb_adr_i[7:0] == `AQSS_ADR_STAT)
                begin
                    rd_val[`AQSS_STAT_CF_BIT]      = s_r.cf;
                    rd_val[`AQSS_STAT_TOR_BIT]     = s_r.tor;
                    rd_val[`AQSS_STAT_PF_BIT]      = s_r.pf;
                    rd_val[`AQSS_STAT_QS_LSB +: 4] = qs;
                end
                else if (wb_adr_i[7:0] == `AQSS_ADR_PTR)
                begin
                    rd_val[`AQSS_PTR_CWP_LSB +: 6] = s_r.command_word_pointer;
                    rd_val[`AQSS_PTR_Q1D_LSB +: 6] = s_r.q1d;
                    // Queue two is inactive, so its pointer rests on the main one
                    rd_val[`AQSS_PTR_Q2D_LSB +: 6] = s_r.command_word_pointer;
                end
            end
            `AQSS_RGN_CCW: rd_val[6:0] = ccw_mem[wb_adr_i[7:2]];
            `AQSS_RGN_RES: rd_val[9:0] = res_mem[wb_adr_i[7:2]];
            default:       rd_val = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_nxt           = s_r;
        s_nxt.sync1     = ext_trig;
        s_nxt.sync2     = s_r.sync1;
        s_nxt.trig_d    = s_r.sync2;
        s_nxt.ack       = acc;
        s_nxt.req.start = 1'b0;
        cf_set          = 1'b0;
        tor_set         = 1'b0;
        res_we          = 1'b0;
        if (acc)
            s_nxt.dat = rd_val;

        unique case (s_r.st)
            ST_OFF:
            begin
                // Nothing moves while the queue is disabled
            end
            ST_ARM:
            begin
                if ((s_r.mode == MODE_EDGE) & rise)
                    s_nxt.st = ST_ISSUE;
                else if (gated & gate & ((s_r.mode == MODE_GCONT) | s_r.single_scan_enable))
                    s_nxt.st = ST_ISSUE;
            end
            ST_ISSUE:
            begin
                if (gated & ~gate)
                begin
                    s_nxt.command_word_pointer    = `AQSS_FIRST_ENTRY;
                    s_nxt.q1d    = `AQSS_FIRST_ENTRY;
                    s_nxt.second = 1'b0;
                    s_nxt.st     = ST_ARM;
                end
                else if (end_here)
                begin
                    cf_set      = 1'b1;
                    s_nxt.eoq   = 1'b0;
                    s_nxt.command_word_pointer   = `AQSS_FIRST_ENTRY;
                    s_nxt.q1d   = `AQSS_FIRST_ENTRY;
                    s_nxt.st    = ST_ARM;
                    if (s_r.mode == MODE_GSINGLE)
                        s_nxt.single_scan_enable = 1'b0;
                    if (s_r.mode == MODE_GCONT)
                    begin
                        tor_set      = s_r.second;
                        s_nxt.second = 1'b1;
                        s_nxt.st     = ST_ISSUE;
                    end
                end
                else
                begin
                    s_nxt.req.start = 1'b1;
                    s_nxt.req.chan  = cur.chan;
                    s_nxt.st        = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (conv_eoc)
                begin
                    res_we    = 1'b1;
                    s_nxt.q1d = s_r.command_word_pointer;
                    if (gated & ~gate)
                    begin
                        // Conversion was let run to its end, now idle
                        s_nxt.command_word_pointer    = `AQSS_FIRST_ENTRY;
                        s_nxt.q1d    = `AQSS_FIRST_ENTRY;
                        s_nxt.second = 1'b0;
                        s_nxt.st     = ST_ARM;
                    end
                    else if ((s_r.mode == MODE_EDGE) & cur.pause)
                    begin
                        s_nxt.pf = 1'b1;
                        s_nxt.st = ST_PAUSE;
                    end
                    else
                    begin
                        s_nxt.command_word_pointer = s_r.command_word_pointer + 6'h01;
                        s_nxt.eoq = (s_r.command_word_pointer == `AQSS_LAST_ENTRY);
                        s_nxt.st  = ST_ISSUE;
                    end
                end
            end
            ST_PAUSE:
            begin
                if (rise)
                begin
                    s_nxt.pf  = 1'b0;
                    s_nxt.command_word_pointer = s_r.command_word_pointer + 6'h01;
                    s_nxt.eoq = (s_r.command_word_pointer == `AQSS_LAST_ENTRY);
                    s_nxt.st  = ST_ISSUE;
                end
            end
            default: s_nxt.st = ST_OFF;
        endcase

        // A mode write aborts the queue, rewinds it to its start and rearms it unless the new mode is off
        if (wr_ctrl)
        begin
            s_nxt.mode   = aqss_mode_e'(wb_dat_i[`AQSS_CTRL_MODE_LSB +: 2]);
            s_nxt.single_scan_enable    = wb_dat_i[`AQSS_CTRL_SSE_BIT];
            s_nxt.ie     = wb_dat_i[`AQSS_CTRL_IE_BIT];
            s_nxt.command_word_pointer    = `AQSS_FIRST_ENTRY;
            s_nxt.q1d    = `AQSS_FIRST_ENTRY;
            s_nxt.pf     = 1'b0;
            s_nxt.eoq    = 1'b0;
            s_nxt.second = 1'b0;
            s_nxt.st     = (s_nxt.mode == MODE_OFF) ? ST_OFF : ST_ARM;
            if (wb_sel_i[1])
                s_nxt.bq2 = wb_dat_i[`AQSS_CTRL_BQ2_LSB +: 6];
        end

        // Sticky flags: a hardware set beats a same-cycle clear
        s_nxt.cf  = cf_set | (s_r.cf & ~(wr_stat & wb_dat_i[`AQSS_STAT_CF_BIT]));
        s_nxt.tor = tor_set | (s_r.tor & ~(wr_stat & wb_dat_i[`AQSS_STAT_TOR_BIT]));
        s_nxt.irq = s_nxt.cf & s_nxt.ie;
    end

    // ----------------------------------------------------------------
    // Registers and tables
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_r      <= '0;
            s_r.st   <= ST_OFF;
            s_r.mode <= MODE_OFF;
            s_r.bq2  <= `AQSS_BQ2_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (wr & (wb_adr_i[9:8] == `AQSS_RGN_CCW) & wb_sel_i[0])
            ccw_mem[wb_adr_i[7:2]] <= aqss_ccw_s'(wb_dat_i[6:0]);
        // Hardware result write wins over a software write in the same cycle
        if (res_we)
            res_mem[s_r.command_word_pointer] <= conv_result;
        else if (wr & (wb_adr_i[9:8] == `AQSS_RGN_RES) & (wb_sel_i[1:0] == 2'h3))
            res_mem[wb_adr_i[7:2]] <= wb_dat_i[9:0];
    end

    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    assign conv_req = s_r.req;
    assign q1_irq   = s_r.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence seq_eoc_edge;
        (s_r.st == ST_CONV) && conv_eoc && (s_r.mode == MODE_EDGE) && !wr_ctrl;
    endsequence

    sequence seq_end_gated;
        (s_r.st == ST_ISSUE) && end_here && gate && !s_r.eoq && !wr_ctrl;
    endsequence

    AST_QS_ENC: assert property (
        (s_r.mode == MODE_OFF) |-> (qs == 4'h0))
        else $error("queue status encoding wrong");
    AST_QS_PAUSED: assert property (
        (s_r.mode != MODE_OFF) |-> (qs == ((s_r.st == ST_PAUSE) ? 4'h4 : 4'h8)))
        else $error("queue status active or paused wrong");
    AST_Q1D_IDLE: assert property (
        (s_r.st inside {ST_OFF, ST_ARM}) |-> (s_r.q1d == s_r.command_word_pointer))
        else $error("last done pointer differs while idle");
    AST_Q1D_EOC: assert property (
        seq_eoc_edge |=> (s_r.q1d == $past(s_r.command_word_pointer)))
        else $error("last done pointer not updated at end of conversion");
    AST_PAUSE_HOLD: assert property (
        seq_eoc_edge ##0 cur.pause |=> (s_r.st == ST_PAUSE) && $stable(s_r.command_word_pointer))
        else $error("pointer moved on entering pause");
    // Checked one cycle at a time so a prompt trigger is still legal
    AST_PAUSE_WAIT: assert property (
        (s_r.st == ST_PAUSE) && !rise && !wr_ctrl
        |=> (s_r.st == ST_PAUSE) && $stable(s_r.command_word_pointer))
        else $error("pointer moved while paused");
    AST_PAUSE_GO: assert property (
        (s_r.st == ST_PAUSE) && rise && !wr_ctrl
        |=> (s_r.command_word_pointer == $past(s_r.command_word_pointer) + 6'h01) && (s_r.st == ST_ISSUE))
        else $error("paused pointer not released by trigger");
    AST_ADVANCE: assert property (
        seq_eoc_edge ##0 !cur.pause |=> (s_r.command_word_pointer == $past(s_r.command_word_pointer) + 6'h01))
        else $error("pointer not advanced at end of conversion");
    AST_RES_IDX: assert property (
        res_we |=> (res_mem[$past(s_r.command_word_pointer)] == $past(conv_result)))
        else $error("result stored at wrong index");
    AST_GATE_CLOSE: assert property (
        (s_r.st == ST_CONV) && gated && !gate && !conv_eoc && !wr_ctrl
        |=> (s_r.st == ST_CONV))
        else $error("conversion abandoned at gate close");
    AST_GATE_RESTART: assert property (
        (s_r.st == ST_CONV) && gated && !gate && conv_eoc && !wr_ctrl
        |=> (s_r.command_word_pointer == 6'h00) && (s_r.st == ST_ARM))
        else $error("gate close did not rewind queue");
    AST_SSE_CLR: assert property (
        seq_end_gated ##0 (s_r.mode == MODE_GSINGLE) |=> s_r.cf && !s_r.single_scan_enable)
        else $error("single scan end flags wrong");
    AST_CONT_RESTART: assert property (
        seq_end_gated ##0 (s_r.mode == MODE_GCONT)
        |=> s_r.cf && (s_r.command_word_pointer == 6'h00) && (s_r.st == ST_ISSUE))
        else $error("continuous scan did not restart");
    AST_TOR: assert property (
        seq_end_gated ##0 (s_r.mode == MODE_GCONT) && s_r.second |=> s_r.tor)
        else $error("overrun not flagged on second pass");
    AST_EOQ_MARK: assert property (
        (s_r.st == ST_ISSUE) && (cur.chan == 6'h3F) && !wr_ctrl
        && !(gated && !gate) |=> !s_r.req.start && s_r.cf)
        else $error("end marker converted");
    AST_EOQ_BQ2: assert property (
        (s_r.st == ST_ISSUE) && (s_r.command_word_pointer == s_r.bq2) && !wr_ctrl
        && !(gated && !gate) |=> !s_r.req.start && s_r.cf)
        else $error("queue two begin not taken as end");
    AST_IRQ: assert property (
        s_r.cf && s_r.ie && !wr_stat && !wr_ctrl |=> q1_irq)
        else $error("interrupt missing");
    AST_OFF_QUIET: assert property (
        (s_r.st == ST_OFF) && !wr_ctrl |=> $stable(s_r.command_word_pointer) && !s_r.req.start && !res_we)
        else $error("disabled queue moved");

endmodule

`default_nettype wire

// ---- bench/aqss_conv_model.sv ----
// Converter model that answers each start pulse with one end-of-conversion pulse.
// Assumes the sequencer drives conv_req on sys_clk; lat sets the answer delay.
`timescale 1ns/10ps
`default_nettype none

module aqss_conv_model
    import aqss_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           rst,
    input  wire logic [7:0]     lat,
    input  wire aqss_conv_req_s conv_req,
    output logic                conv_eoc,
    output logic [9:0]          conv_result
);
    // ------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------
    logic [7:0] cnt_r;
    logic       busy_r;
    logic [5:0] chan_r;

    always_ff @(posedge sys_clk)
    begin
        conv_eoc <= 1'b0;
        // Toggle outside the valid cycle so a late sample never matches
        conv_result <= ~conv_result;
        if (rst)
        begin
            busy_r      <= 1'b0;
            cnt_r       <= 8'h00;
            conv_result <= 10'h2AA;
        end
        else if (conv_req.start)
        begin
            busy_r <= 1'b1;
            cnt_r  <= lat;
            chan_r <= conv_req.chan;
        end
        else if (busy_r && cnt_r <= 8'h01)
        begin
            busy_r      <= 1'b0;
            conv_eoc    <= 1'b1;
            conv_result <= {4'hA, chan_r};
        end
        else if (busy_r)
        begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
endmodule

`default_nettype wire

// ---- bench/aqss_top_tb.sv ----
// Self-checking bench of the queue scan sequencer.
// Assumes the converter model sits on the conversion port; bus is classic Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "aqss_params.svh"

module aqss_top_tb
    import aqss_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic        we;
        logic [9:0]  adr;
        logic [31:0] dat;
        logic [31:0] exp;
    } aqss_row_s;

    logic           sys_clk = 1'b0;
    logic           rst;
    logic           wb_cyc;
    logic           wb_stb;
    logic           wb_we;
    logic [9:0]     wb_adr;
    logic [31:0]    wb_dat;
    logic [31:0]    wb_dat_o;
    logic           wb_ack_o;
    logic           ext_trig;
    logic           conv_eoc;
    logic [9:0]     conv_result;
    aqss_conv_req_s conv_req;
    logic           q1_irq;
    logic [7:0]     lat;
    int             fail_count = 0;
    int             num_checks = 0;
    int             cycles = 0;
    int             starts = 0;
    int             s0;
    logic [31:0]    st;
    aqss_row_s      rows [9];

    localparam logic [9:0] CTRL = {2'h0, `AQSS_ADR_CTRL};
    localparam logic [9:0] STAT = {2'h0, `AQSS_ADR_STAT};
    localparam logic [9:0] PTR  = {2'h0, `AQSS_ADR_PTR};

    always #2.5 sys_clk = ~sys_clk;

    aqss_top dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_sel_i(4'hF), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_trig(ext_trig), .conv_eoc(conv_eoc),
        .conv_result(conv_result), .conv_req(conv_req), .q1_irq(q1_irq));

    aqss_conv_model conv (.sys_clk(sys_clk), .rst(rst), .lat(lat), .conv_req(conv_req),
        .conv_eoc(conv_eoc), .conv_result(conv_result));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] conversion_command_word(input int n);
        return 10'h100 + 10'(4 * n);
    endfunction

    function automatic logic [9:0] rsa(input int n);
        return 10'h200 + 10'(4 * n);
    endfunction

    function automatic logic [31:0] res(input logic [5:0] ch);
        return {22'h0, 4'hA, ch};
    endfunction

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t pin %b expected %b", $time, got, exp);
            fail_count++;
        end
    endtask

    // Holds the request until ack is sampled high, then releases it
    task automatic wb_acc(input logic we, input logic [9:0] adr, input logic [31:0] wd,
                          output logic [31:0] rd);
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= wd;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1)
            @(posedge sys_clk);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] adr, input logic [31:0] d);
        logic [31:0] x;
        wb_acc(1'b1, adr, d, x);
    endtask

    task automatic rd(input logic [9:0] adr, output logic [31:0] d);
        wb_acc(1'b0, adr, 32'h0, d);
    endtask

    task automatic wait_start;
        @(posedge sys_clk);
        while (conv_req.start !== 1'b1)
            @(posedge sys_clk);
    endtask

    task automatic wait_eoc;
        @(posedge sys_clk);
        while (conv_eoc !== 1'b1)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
    endtask

    // Reads status until every bit of mask is set
    task automatic poll(input logic [31:0] mask);
        rd(STAT, st);
        while ((st & mask) !== mask)
            rd(STAT, st);
    endtask

    task automatic pulse_trig;
        @(posedge sys_clk);
        ext_trig <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext_trig <= 1'b0;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (conv_req.start === 1'b1)
            starts++;
        if (cycles == 20000)
        begin
            fail_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0;
        wb_adr = 10'h0; wb_dat = 32'h0; ext_trig = 1'b0; lat = 8'd20;
        rows = '{'{1'b0, CTRL, 32'h0, 32'h00003F00}, '{1'b0, STAT, 32'h0, 32'h0},
                 '{1'b0, PTR, 32'h0, 32'h0}, '{1'b1, 10'h300, 32'hFFFFFFFF, 32'h0},
                 '{1'b0, 10'h300, 32'h0, 32'h0}, '{1'b1, conversion_command_word(5), 32'hFFFFFFFF, 32'h0},
                 '{1'b0, conversion_command_word(5), 32'h0, 32'h7F}, '{1'b1, rsa(5), 32'hFFFFFFFF, 32'h0},
                 '{1'b0, rsa(5), 32'h0, 32'h3FF}};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            if (rows[i].we)
                wr(rows[i].adr, rows[i].dat);
            else
            begin
                rd(rows[i].adr, st);
                check32(st, rows[i].exp);
            end
        end
        $display("test registers done");
        // Edge trigger, first word pauses, third word ends the queue
        wr(conversion_command_word(0), 32'h45);
        wr(conversion_command_word(1), 32'h07);
        wr(conversion_command_word(2), 32'h3F);
        wr(rsa(0), 32'h0);
        wr(rsa(1), 32'h0);
        wr(CTRL, 32'h3F09);
        pulse_trig();
        wait_eoc();
        rd(STAT, st); check32(st, 32'h44);
        rd(rsa(0), st); check32(st, res(6'h05));
        pulse_trig();
        wait_start();
        rd(PTR, st); check32(st, 32'h00010001);
        wait_eoc();
        rd(rsa(1), st); check32(st, res(6'h07));
        rd(STAT, st); check32(st & 32'h7, 32'h1);
        rd(PTR, st); check32(st, 32'h0);
        check1(q1_irq, 1'b1);
        wr(STAT, 32'h1);
        check1(q1_irq, 1'b0);
        wr(CTRL, 32'h3F00);
        s0 = starts;
        pulse_trig();
        repeat (20) @(posedge sys_clk);
        check32(32'(starts - s0), 32'h0);
        rd(PTR, st); check32(st, 32'h0);
        $display("test edge done");
        // Gated single scan, prompt converter
        lat = 8'd1;
        wr(conversion_command_word(0), 32'h01);
        wr(conversion_command_word(1), 32'h02);
        wr(conversion_command_word(2), 32'h03);
        wr(conversion_command_word(3), 32'h3F);
        wr(CTRL, 32'h3F06);
        ext_trig <= 1'b1;
        poll(32'h1);
        rd(CTRL, st); check32(st, 32'h3F02);
        rd(rsa(2), st); check32(st, res(6'h03));
        ext_trig <= 1'b0;
        wr(STAT, 32'h1);
        // Gate closes in mid-conversion, slow converter
        lat = 8'd20;
        wr(rsa(0), 32'h0);
        wr(CTRL, 32'h3F06);
        ext_trig <= 1'b1;
        wait_start();
        ext_trig <= 1'b0;
        wait_eoc();
        rd(rsa(0), st); check32(st, res(6'h01));
        rd(PTR, st); check32(st, 32'h0);
        s0 = starts;
        repeat (20) @(posedge sys_clk);
        check32(32'(starts - s0), 32'h0);
        ext_trig <= 1'b1;
        wait_start();
        check32({26'h0, conv_req.chan}, 32'h1);
        poll(32'h1);
        ext_trig <= 1'b0;
        $display("test gated single done");
        // Gated continuous scan, two full passes
        wr(STAT, 32'h3);
        wr(CTRL, 32'h3F03);
        ext_trig <= 1'b1;
        poll(32'h1);
        check32(st & 32'h3, 32'h1);
        wait_start();
        check32({26'h0, conv_req.chan}, 32'h2);
        poll(32'h2);
        check32(st & 32'h3, 32'h3);
        ext_trig <= 1'b0;
        $display("test gated continuous done");
        // Queue one ends at the queue two begin pointer, before the marker
        wait_eoc();
        wr(STAT, 32'h3);
        wr(CTRL, 32'h0206);
        s0 = starts;
        ext_trig <= 1'b1;
        poll(32'h1);
        ext_trig <= 1'b0;
        check32(32'(starts - s0), 32'h2);
        rd(CTRL, st); check32(st, 32'h0202);
        rd(PTR, st); check32(st, 32'h0);
        $display("test queue boundary done");
        summarize();
    end
endmodule

`default_nettype wire
